// >>> pbsp_ctl_model.sv
`timescale 1ns/1ps

module pbsp_ctl_model
  import pbsp_pkg::*;
(
  input  wire logic         i_core_clk,
  output logic              o_qual_n,
  output logic [2:0]        o_sel,
  output logic              o_load_n,
  output logic              o_wr_n,
  output logic [LANES-1:0]  o_lane_n,
  output logic [ADDR_W-1:0] o_addr,
  output logic [35:0]       o_wd,
  output logic              o_drv
);
  logic [35:0] s0_d;
  logic [35:0] s1_d;
  logic        s0_v = 1'b0;
  logic        s1_v = 1'b0;
  logic        dir_wr = 1'b0;

  initial begin
    o_qual_n = 1'b0;
    o_sel    = 3'h5;
    o_load_n = 1'b0;
    o_wr_n   = 1'b1;
    o_lane_n = LANES_OFF;
    o_addr   = '0;
    o_wd     = '0;
    o_drv    = 1'b0;
  end

  task automatic beat(input logic q_n, input logic sel, input logic ld_n,
                      input logic wr_n, input logic [LANES-1:0] ln,
                      input logic [ADDR_W-1:0] a, input logic [35:0] wd);
    @(negedge i_core_clk);
    o_qual_n = q_n;
    o_sel    = sel ? 3'h2 : 3'h5;
    o_load_n = ld_n;
    o_wr_n   = wr_n;
    o_lane_n = ln;
    o_addr   = a;
    if (!q_n) begin
      o_drv = s1_v;
      o_wd  = s1_v ? s1_d : ~o_wd;
      s1_v  = s0_v;
      s1_d  = s0_d;
      if (!ld_n)
        dir_wr = sel && !wr_n;
      s0_v = dir_wr;
      s0_d = wd;
    end
  endtask : beat
endmodule : pbsp_ctl_model

// >>> pbsp_pkg.sv
package pbsp_pkg;
  localparam int ADDR_W     = 18;
  localparam int LANES      = 4;
  localparam int BYTE_W     = 8;
  localparam int DATA_W     = LANES * BYTE_W;
  localparam int LANE_W     = BYTE_W + 1;
  localparam int BURST_W    = 2;
  localparam int HI_W       = ADDR_W - BURST_W;
  localparam int FIFO_W     = ADDR_W + LANES + LANES * LANE_W;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_AW    = 3;
  localparam int SYNC_N     = 3;

  localparam logic [BURST_W-1:0] BEAT_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] BEAT_ONE  = 2'h1;
  localparam logic [LANES-1:0]   LANES_OFF = 4'hf;
  // async input slots in the synchroniser bank
  localparam int SY_OE    = 0;
  localparam int SY_SLEEP = 1;
  localparam int SY_ORDER = 2;
  // oe_n idles high (float), sleep and order idle low
  localparam logic [SYNC_N-1:0] SYNC_RST = 3'h1;

  typedef enum logic [2:0] {
    PBSP_DESEL = 3'b001,
    PBSP_READ  = 3'b010,
    PBSP_WRITE = 3'b100
  } pbsp_cmd_e;
endpackage : pbsp_pkg

// >>> pbsp_sram_port.sv
// Functional notes
// - inputs registered on rising edge; read data driven from output flops
// - clock qualifier high freezes every piece of state for that edge
// - all selects active, write select high, load low: read loads address
// - read data appears at the edge after the address edge
// - data drives only while output-drive enable is low, plus internal control
// - any command may follow any command with no idle cycle
// - deselect is pipelined; outputs float from the next edge
// - all selects active, write select low: write loads address and controls
// - edge after a write command floats data and parity lines
// - that same edge also registers the next command
// - write data is taken two edges after the write command
// - only byte lanes with active low selects are written
// - burst counter gives up to four beats from one address
// - order strap low is linear, high is interleaved
// - counter works on the two low address bits and wraps
// - load/advance high steps counter, ignoring selects and write select
// - read or write direction is kept for the whole burst
// - sleep input high floats outputs and keeps stored data
// - parity lines follow their byte lane and its select
// - outputs float in the first clock after leaving deselect
// - beat is start xor count, or start plus count modulo four
`timescale 1ns/1ps

module pbsp_fifo #(
  parameter int W  = 8,
  parameter int D  = 8,
  parameter int AW = 3
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          rdy_q, rdy_d, push, pop;

  assign o_in_ready  = rdy_q;
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem_q[rp_q];

  always_comb begin
    push  = i_ce & i_in_valid & rdy_q;
    pop   = i_ce & o_out_valid & i_out_ready;
    wp_d  = push ? AW'(wp_q + 1'b1) : wp_q;
    rp_d  = pop ? AW'(rp_q + 1'b1) : rp_q;
    cnt_d = (AW+1)'(cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    // registered ready, so full is judged on the count after this edge
    rdy_d = (cnt_d != (AW+1)'(D));
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b1;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_q[wp_q] <= i_in_data;
    end
  end
endmodule : pbsp_fifo

module pbsp_sram_port
  import pbsp_pkg::*;
(
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  input  wire logic              i_clk_qualify_n,
  input  wire logic              i_chip_sel_1_n,
  input  wire logic              i_chip_sel_2,
  input  wire logic              i_chip_sel_3_n,
  input  wire logic              i_burst_step_load_n,
  input  wire logic              i_wr_sel_n,
  input  wire logic [LANES-1:0]  i_byte_lane_sel_n,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_dq,
  output logic [DATA_W-1:0]      o_dq,
  output logic                   o_dq_oe,
  input  wire logic [LANES-1:0]  i_parity_io,
  output logic [LANES-1:0]       o_parity_io,
  output logic                   o_parity_oe,
  input  wire logic              i_out_drive_n,
  input  wire logic              i_sleep_req,
  input  wire logic              i_burst_order,
  output logic                   o_wr_ready
);
  logic ce;
  assign ce = ~i_clk_qualify_n;

  // async pins: three flops, accepted once flops two and three agree
  logic [SYNC_N-1:0] sy1_q, sy2_q, sy3_q, st_q, st_d;
  logic [SYNC_N-1:0] async_in;
  assign async_in = {i_burst_order, i_sleep_req, i_out_drive_n};
  genvar g;
  generate
    for (g = 0; g < SYNC_N; g++) begin : g_sync
      always_comb begin
        st_d[g] = (sy2_q[g] == sy3_q[g]) ? sy3_q[g] : st_q[g];
      end
      always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
          sy1_q[g] <= SYNC_RST[g];
          sy2_q[g] <= SYNC_RST[g];
          sy3_q[g] <= SYNC_RST[g];
          st_q[g]  <= SYNC_RST[g];
        end else if (ce) begin
          sy1_q[g] <= async_in[g];
          sy2_q[g] <= sy1_q[g];
          sy3_q[g] <= sy2_q[g];
          st_q[g]  <= st_d[g];
        end
      end
    end
  endgenerate

  logic oe_n_st, sleep_st, order_st;
  assign oe_n_st  = st_q[SY_OE];
  assign sleep_st = st_q[SY_SLEEP];
  assign order_st = st_q[SY_ORDER];

  // command stage: the beat now addressed
  pbsp_cmd_e            cmd_q, cmd_d;
  logic [HI_W-1:0]      hi_q, hi_d;
  logic [BURST_W-1:0]   start_q, start_d, cnt_q, cnt_d, beat;
  logic [LANES-1:0]     lsel_q, lsel_d;
  logic [ADDR_W-1:0]    beat_addr;
  logic                 cs_ok, load;

  assign cs_ok = ~i_chip_sel_1_n & i_chip_sel_2 & ~i_chip_sel_3_n;
  assign load  = ~i_burst_step_load_n;

  always_comb begin
    cmd_d   = cmd_q;
    hi_d    = hi_q;
    start_d = start_q;
    cnt_d   = cnt_q;
    lsel_d  = i_byte_lane_sel_n;
    if (sleep_st) begin
      cmd_d = PBSP_DESEL;
    end else if (load) begin
      if (cs_ok) begin
        cmd_d   = i_wr_sel_n ? PBSP_READ : PBSP_WRITE;
        hi_d    = i_addr[ADDR_W-1:BURST_W];
        start_d = i_addr[BURST_W-1:0];
        cnt_d   = BEAT_ZERO;
      end else begin
        cmd_d = PBSP_DESEL;
      end
    end else if (cmd_q != PBSP_DESEL) begin
      cnt_d = BURST_W'(cnt_q + BEAT_ONE);
    end
  end

  always_comb begin
    beat      = order_st ? (start_q ^ cnt_q) : BURST_W'(start_q + cnt_q);
    beat_addr = {hi_q, beat};
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cmd_q   <= PBSP_DESEL;
      hi_q    <= '0;
      start_q <= BEAT_ZERO;
      cnt_q   <= BEAT_ZERO;
      lsel_q  <= LANES_OFF;
    end else if (ce) begin
      cmd_q   <= cmd_d;
      hi_q    <= hi_d;
      start_q <= start_d;
      cnt_q   <= cnt_d;
      lsel_q  <= lsel_d;
    end
  end

  // data stage: write beat waiting for its data
  logic                wr2_q, wr2_d;
  logic [ADDR_W-1:0]   a2_q, a2_d;
  logic [LANES-1:0]    bw2_q, bw2_d;

  always_comb begin
    wr2_d = (cmd_q == PBSP_WRITE) & (lsel_q != LANES_OFF);
    a2_d  = beat_addr;
    bw2_d = lsel_q;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wr2_q <= 1'b0;
      a2_q  <= '0;
      bw2_q <= LANES_OFF;
    end else if (ce) begin
      wr2_q <= wr2_d;
      a2_q  <= a2_d;
      bw2_q <= bw2_d;
    end
  end

  // writes queue in a small fifo so sleep can hold off the array
  logic [LANES*LANE_W-1:0] wr_word, head_word, mem_word, fwd_word;
  logic [FIFO_W-1:0]       fifo_in, fifo_out;
  logic                    fifo_push, fifo_rdy, head_vld, drain;
  logic [ADDR_W-1:0]       head_addr;
  logic [LANES-1:0]        head_lsel;

  assign fifo_push = wr2_q;
  assign drain     = ~sleep_st;
  assign fifo_in   = {a2_q, bw2_q, wr_word};
  assign {head_addr, head_lsel, head_word} = fifo_out;

  pbsp_fifo #(
    .W  (FIFO_W),
    .D  (FIFO_DEPTH),
    .AW (FIFO_AW)
  ) u_wfifo (
    .i_core_clk  (i_core_clk),
    .i_rst       (i_rst),
    .i_ce        (ce),
    .i_in_valid  (fifo_push),
    .o_in_ready  (fifo_rdy),
    .i_in_data   (fifo_in),
    .o_out_valid (head_vld),
    .i_out_ready (drain),
    .o_out_data  (fifo_out)
  );

  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [LANE_W-1:0] lane_mem [2**ADDR_W];
      logic              hit;
      assign wr_word[g*LANE_W +: LANE_W] =
        {i_parity_io[g], i_dq[g*BYTE_W +: BYTE_W]};
      assign mem_word[g*LANE_W +: LANE_W] = lane_mem[beat_addr];
      // only the head is forwarded; deeper entries build up only in sleep and drain after it
      assign hit = head_vld & ~head_lsel[g] & (head_addr == beat_addr);
      assign fwd_word[g*LANE_W +: LANE_W] = hit ?
        head_word[g*LANE_W +: LANE_W] : mem_word[g*LANE_W +: LANE_W];
      always_ff @(posedge i_core_clk) begin
        if (ce & head_vld & drain & ~head_lsel[g]) begin
          lane_mem[head_addr] <= head_word[g*LANE_W +: LANE_W];
        end
      end
    end
  endgenerate

  // output stage
  logic [DATA_W-1:0] dq_d;
  logic [LANES-1:0]  par_d;
  logic              oe_d;

  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      dq_d[i*BYTE_W +: BYTE_W] = fwd_word[i*LANE_W +: BYTE_W];
      par_d[i] = fwd_word[i*LANE_W + BYTE_W];
    end
    oe_d = (cmd_q == PBSP_READ) & ~oe_n_st & ~sleep_st;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dq        <= '0;
      o_parity_io <= '0;
      o_dq_oe     <= 1'b0;
      o_parity_oe <= 1'b0;
      o_wr_ready  <= 1'b1;
    end else if (ce) begin
      o_dq        <= dq_d;
      o_parity_io <= par_d;
      o_dq_oe     <= oe_d;
      o_parity_oe <= oe_d;
      o_wr_ready  <= fifo_rdy;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  sequence rd_load_s;
    ce & ~sleep_st & load & cs_ok & i_wr_sel_n;
  endsequence
  sequence wr_load_s;
    ce & ~sleep_st & load & cs_ok & ~i_wr_sel_n;
  endsequence
  sequence wr_beat_s;
    ce & (cmd_q == PBSP_WRITE) & (lsel_q != LANES_OFF);
  endsequence

  read_load_a: assert property (rd_load_s |=> cmd_q == PBSP_READ
    && cnt_q == BEAT_ZERO) else $error("read load missed");
  write_load_a: assert property (wr_load_s |=> cmd_q == PBSP_WRITE
    && cnt_q == BEAT_ZERO) else $error("write load missed");
  read_drive_a: assert property (rd_load_s ##1 (ce & ~oe_n_st)
    |=> o_dq_oe) else $error("read data not driven");
  write_float_a: assert property (wr_load_s ##1 ce
    |=> !o_dq_oe && !o_parity_oe) else $error("driving during write");
  desel_float_a: assert property (ce & (cmd_q == PBSP_DESEL)
    |=> !o_dq_oe) else $error("deselect not floated");
  qual_freeze_a: assert property (!ce |=> $stable(cmd_q)
    && $stable(cnt_q) && $stable(o_dq_oe)) else $error("state moved");
  burst_step_a: assert property (ce & ~sleep_st & ~load
    & (cmd_q != PBSP_DESEL) |=> cnt_q == BURST_W'($past(cnt_q) + 1)
    && cmd_q == $past(cmd_q)) else $error("burst step wrong");
  write_push_a: assert property (wr_beat_s ##1 ce
    |-> fifo_push && a2_q == $past(beat_addr)) else $error("write lost");
  parity_oe_a: assert property (o_parity_oe == o_dq_oe)
    else $error("parity enable differs");
  sleep_float_a: assert property (ce & sleep_st
    |=> !o_dq_oe ##1 (!ce || cmd_q == PBSP_DESEL))
    else $error("sleep not floated");
endmodule : pbsp_sram_port

// >>> tb_pipelined_burst_sram_port.sv
`timescale 1ns/1ps

module tb_pipelined_burst_sram_port;
  import pbsp_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              order = 1'b0;
  logic              sleep = 1'b0;
  logic              oe_n = 1'b0;
  logic              q_n, ld_n, wr_n, drv, dq_oe, par_oe, wr_rdy;
  logic [2:0]        sel;
  logic [LANES-1:0]  lane_n, par, par_bus;
  logic [ADDR_W-1:0] addr, base;
  logic [35:0]       wd, e0_d, e1_d;
  logic [31:0]       dq, dq_bus;
  logic [1:0]        cnt;
  logic              e0_v = 1'b0;
  logic              e1_v = 1'b0;
  logic              act = 1'b0;
  logic              dwr = 1'b0;
  // reference image; scenarios only touch words below 0x400
  logic [35:0]       mem [1024];
  int                error_cnt = 0;
  int                total_checks = 0;

  // released lines read the controller's toggling pattern
  assign dq_bus  = dq_oe ? dq : wd[31:0];
  assign par_bus = par_oe ? par : wd[35:32];

  pbsp_ctl_model ctl (.i_core_clk(clk), .o_qual_n(q_n), .o_sel(sel),
    .o_load_n(ld_n), .o_wr_n(wr_n), .o_lane_n(lane_n), .o_addr(addr),
    .o_wd(wd), .o_drv(drv));

  pbsp_sram_port uut (.i_core_clk(clk), .i_rst(rst), .i_clk_qualify_n(q_n),
    .i_chip_sel_1_n(sel[2]), .i_chip_sel_2(sel[1]), .i_chip_sel_3_n(sel[0]),
    .i_burst_step_load_n(ld_n), .i_wr_sel_n(wr_n),
    .i_byte_lane_sel_n(lane_n), .i_addr(addr), .i_dq(dq_bus), .o_dq(dq),
    .o_dq_oe(dq_oe), .i_parity_io(par_bus), .o_parity_io(par),
    .o_parity_oe(par_oe), .i_out_drive_n(oe_n), .i_sleep_req(sleep),
    .i_burst_order(order), .o_wr_ready(wr_rdy));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp

  // one bus beat; judges what the edge two qualified beats back produced
  task automatic op(input logic q, input logic s, input logic l,
                    input logic w, input logic [LANES-1:0] ln,
                    input logic [ADDR_W-1:0] a, input logic [35:0] d);
    logic [ADDR_W-1:0] ba;
    logic              rd_on;
    ctl.beat(q, s, l, w, ln, a, d);
    cmp({34'h0, dq_oe, par_oe}, {34'h0, e1_v, e1_v});
    if (e1_v)
      cmp({par, dq}, e1_d);
    cmp({35'h0, drv & dq_oe}, 36'h0);
    if (!q) begin
      if (!l) begin
        base = a;
        cnt  = 2'h0;
        act  = s;
        dwr  = !w;
      end else
        cnt = cnt + 2'h1;
      ba = {base[ADDR_W-1:2], order ? base[1:0] ^ cnt : base[1:0] + cnt};
      rd_on = act && !dwr && !sleep;
      if (act && dwr && !sleep)
        for (int g = 0; g < LANES; g++)
          if (!ln[g]) begin
            mem[ba[9:0]][g*8 +: 8] = d[g*8 +: 8];
            mem[ba[9:0]][32+g]     = d[32+g];
          end
      e1_v = e0_v;
      e1_d = e0_d;
      e0_v = rd_on && !oe_n;
      e0_d = rd_on ? mem[ba[9:0]] : 36'h0;
    end
  endtask : op

  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, 1'b0, 1'b1, LANES_OFF, '0, '0);
  endtask : idle

  task automatic rd(input logic [ADDR_W-1:0] a);
    op(1'b0, 1'b1, 1'b0, 1'b1, LANES_OFF, a, '0);
  endtask : rd

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [3:0] ln,
                    input logic [35:0] d);
    op(1'b0, 1'b1, 1'b0, 1'b0, ln, a, d);
  endtask : wr

  // advance with selects off and write select low: both must be ignored
  task automatic adv(input logic [3:0] ln, input logic [35:0] d);
    op(1'b0, 1'b0, 1'b1, 1'b0, ln, '0, d);
  endtask : adv

  function automatic logic [35:0] pat(input logic [7:0] i);
    return {i[3:0], {4{i ^ 8'h5a}}};
  endfunction : pat

  task automatic t_burst;
    wr(18'h100, 4'h0, pat(8'h10));
    for (int i = 1; i < 4; i++) adv(4'h0, pat(8'h10 + i[7:0]));
    wr(18'h103, 4'h5, pat(8'h20));
    adv(4'ha, pat(8'h21));
    rd(18'h101);
    for (int i = 1; i < 4; i++) adv(4'hf, '0);
    idle(2);
  endtask : t_burst

  task automatic t_order;
    order = 1'b1;
    idle(6);
    rd(18'h101);
    for (int i = 1; i < 4; i++) adv(4'hf, '0);
    idle(2);
    order = 1'b0;
    idle(6);
  endtask : t_order

  task automatic t_b2b;
    wr(18'h200, 4'h0, pat(8'h30));
    rd(18'h100);
    rd(18'h200);
    wr(18'h200, LANES_OFF, pat(8'h31));
    idle(1);
    rd(18'h200);
    idle(2);
  endtask : t_b2b

  task automatic t_stall;
    rd(18'h100);
    // stalled edges carry a deselect and a write that must be ignored
    op(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 18'h3, '0);
    op(1'b1, 1'b1, 1'b0, 1'b0, 4'h0, 18'h3, '0);
    adv(4'hf, '0);
    idle(2);
  endtask : t_stall

  task automatic t_oe_sleep;
    oe_n = 1'b1;
    idle(6);
    rd(18'h100);
    idle(2);
    oe_n = 1'b0;
    sleep = 1'b1;
    idle(6);
    wr(18'h100, 4'h0, pat(8'h40));
    rd(18'h100);
    idle(2);
    sleep = 1'b0;
    idle(6);
    rd(18'h100);
    idle(2);
  endtask : t_oe_sleep

  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    cmp({34'h0, dq_oe, wr_rdy}, 36'h1);
    rst = 1'b0;
    idle(6);
    t_burst();
    t_order();
    t_b2b();
    t_stall();
    t_oe_sleep();
    cmp({35'h0, wr_rdy}, 36'h1);
    stop_test();
  end

  initial begin
    #20000;
    error_cnt++;
    stop_test();
  end
endmodule : tb_pipelined_burst_sram_port
